//--- rtl/adc_control.sv
// converter control: registers, sequencing, accumulation, interrupt
// assumes: analog core answers sample requests with done and data
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module adc_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // register port
  input  wire logic [4:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // system
  input  wire logic       standby_in,
  input  wire logic       trigger_in,
  // analog core
  output logic            conv_on_out,
  output logic            sample_req_out,
  output logic            sample_open_out,
  input  wire logic       sample_done_in,
  input  wire logic [9:0] sample_data_in,
  output logic            conv_tick_out,
  output logic      [1:0] reference_choice_out,
  output logic            sample_cap_reduce_out,
  output logic      [4:0] input_select_out,
  output logic      [4:0] sample_len_out,
  // interrupt
  output logic            irq_out
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_INIT  = 5'b00010,
    ST_SAMP  = 5'b00100,
    ST_GAP   = 5'b01000,
    ST_DONE  = 5'b10000
  } state_t;

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  control_a_r, control_b_r, control_c_r, control_d_r;
  logic [7:0]  control_e_r, sample_len_r, input_sel_r, trigger_r;
  logic [7:0]  irq_en_r, irq_flags_r, halt_r, scratch_r, trim_r;
  logic [15:0] result_r, win_lo_r, win_hi_r, acc_r;
  logic        start_r, trig_d_r, need_init_r;
  logic [1:0]  ref_prev_r;
  logic [6:0]  count_r;
  logic [8:0]  wait_r;
  logic [3:0]  dly_r;
  logic [7:0]  rdata_r;
  state_t      state_r, state_nxt;

  wire sel_a  = addr_in == OFS_CONTROL_A;
  wire sel_b  = addr_in == OFS_CONTROL_B;
  wire sel_c  = addr_in == OFS_CONTROL_C;
  wire sel_d  = addr_in == OFS_CONTROL_D;
  wire sel_e  = addr_in == OFS_CONTROL_E;
  wire sel_l  = addr_in == OFS_SAMPLE_LEN;
  wire sel_m  = addr_in == OFS_INPUT_SEL;
  wire sel_cm = addr_in == OFS_COMMAND;
  wire sel_t  = addr_in == OFS_TRIGGER;
  wire sel_ie = addr_in == OFS_IRQ_EN;
  wire sel_if = addr_in == OFS_IRQ_FLAGS;
  wire sel_h  = addr_in == OFS_HALT;
  wire sel_s  = addr_in == OFS_SCRATCH;
  wire sel_rl = addr_in == OFS_RESULT_LO;
  wire sel_rh = addr_in == OFS_RESULT_HI;
  wire sel_ca = addr_in == OFS_TRIM;

  //////////////////////////////////////////////////////////////////////////
  // control decode
  // converter power
  wire enable      = control_a_r[POS_ENABLE];
  wire active      = enable &&
                     (!standby_in || control_a_r[POS_STBY_RUN]);
  wire res8        = control_a_r[POS_RES_SEL];
  // reserved code treated as single sample
  wire [2:0] acc_code = (control_b_r[2:0] == ACC_RESERVED) ?
                        3'h0 : control_b_r[2:0];
  wire [6:0] acc_last = 7'((8'h01 << acc_code) - 8'h01);
  // startup delay, reserved codes as zero
  wire [2:0] init_code = control_d_r[7:POS_STARTUP];
  wire [8:0] init_len  = (init_code == 3'h0 || init_code > DLY_MAX_CODE) ?
                         9'h000 :
                         9'((STARTUP_UNIT) << (init_code - 3'h1));
  wire       dither    = control_d_r[POS_DITHER];
  wire       conv_tick;
  wire       trig_rise = trigger_in && !trig_d_r && trigger_r[0];
  wire       start_wr  = wr_in && sel_cm && wdata_in[0];
  wire       go        = (start_wr || trig_rise) && active;

  wire [15:0] sample_val = res8 ? {8'h00, sample_data_in[9:2]} :
                                  {6'h00, sample_data_in};
  wire [15:0] acc_sum    = acc_r + sample_val;
  wire        last       = count_r == acc_last;
  wire        ref_change = control_c_r[5:4] == REF_INTERNAL &&
                           ref_prev_r != REF_INTERNAL;

  // window compare on finished result
  wire [15:0] fin   = acc_sum;
  wire [2:0]  wmode = control_e_r[2:0];
  wire win_hit = (wmode == 3'h1 && fin < win_lo_r) ||
                 (wmode == 3'h2 && fin > win_hi_r) ||
                 (wmode == 3'h3 && fin > win_lo_r && fin < win_hi_r) ||
                 (wmode == 3'h4 && (fin < win_lo_r || fin > win_hi_r));

  //////////////////////////////////////////////////////////////////////////
  // prescaler
  // converter clock enable
  adc_clk_divider u_div (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .run_in   (active),
    .code_in  (control_c_r[2:0]),
    .tick_out (conv_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = (need_init_r && init_len != 9'h000) ?
                      ST_INIT : ST_SAMP;
        end
      end
      ST_INIT: begin
        if (conv_tick && wait_r == 9'h001) begin
          state_nxt = ST_SAMP;
        end
      end
      ST_SAMP: begin
        if (sample_done_in) begin
          if (last) begin
            state_nxt = ST_DONE;
          end else if (dly_r != 4'h0) begin
            state_nxt = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        if (conv_tick && wait_r == 9'h001) begin
          state_nxt = ST_SAMP;
        end
      end
      ST_DONE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
    if (!active) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wait_r <= 9'h000;
    end else if (state_r == ST_IDLE && go) begin
      wait_r <= init_len;
    end else if (state_r == ST_SAMP && sample_done_in) begin
      wait_r <= {5'h00, dly_r};
    end else if (conv_tick && wait_r != 9'h000) begin
      wait_r <= wait_r - 9'h001;
    end
  end

  // startup needed after enable or switch to internal reference
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      need_init_r <= 1'b1;
      ref_prev_r  <= REF_INTERNAL;
      trig_d_r    <= 1'b0;
    end else begin
      ref_prev_r <= control_c_r[5:4];
      trig_d_r   <= trigger_in;
      if (!active || ref_change) begin
        need_init_r <= 1'b1;
      end else if (state_r == ST_INIT) begin
        need_init_r <= 1'b0;
      end else if (state_r == ST_IDLE && go && init_len == 9'h000) begin
        need_init_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      acc_r   <= 16'h0000;
      count_r <= 7'h00;
    end else if (state_r == ST_IDLE) begin
      acc_r   <= 16'h0000;
      count_r <= 7'h00;
    end else if (state_r == ST_SAMP && sample_done_in) begin
      acc_r   <= acc_sum;
      count_r <= count_r + 7'h01;
    end
  end

  // delay dither increments per sample, wraps
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dly_r <= 4'h0;
    end else if (wr_in && sel_d) begin
      dly_r <= wdata_in[3:0];
    end else if (dither && state_r == ST_SAMP && sample_done_in) begin
      dly_r <= (dly_r == DITHER_WRAP) ? 4'h0 : dly_r + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes
  // masked writes, reserved bits stay zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      control_a_r  <= REG_RESET;
      control_b_r  <= REG_RESET;
      control_c_r  <= REG_RESET;
      control_d_r  <= REG_RESET;
      control_e_r  <= REG_RESET;
      sample_len_r <= REG_RESET;
      input_sel_r  <= REG_RESET;
      trigger_r    <= REG_RESET;
      irq_en_r     <= REG_RESET;
      halt_r       <= REG_RESET;
      scratch_r    <= REG_RESET;
      trim_r       <= REG_RESET;
      win_lo_r     <= 16'h0000;
      win_hi_r     <= 16'h0000;
    end else if (wr_in) begin
      if (sel_a)  control_a_r  <= wdata_in & MASK_CTRL_A;
      if (sel_b)  control_b_r  <= wdata_in & MASK_CTRL_B;
      if (sel_c)  control_c_r  <= wdata_in & MASK_CTRL_C;
      if (sel_d)  control_d_r  <= {wdata_in[7:4], 4'h0};
      if (sel_e)  control_e_r  <= wdata_in & MASK_CTRL_E;
      if (sel_l)  sample_len_r <= wdata_in & MASK_5BIT;
      if (sel_m)  input_sel_r  <= wdata_in & MASK_5BIT;
      if (sel_t)  trigger_r    <= wdata_in & MASK_BIT0;
      if (sel_ie) irq_en_r     <= wdata_in & MASK_IRQ;
      if (sel_h)  halt_r       <= wdata_in & MASK_BIT0;
      if (sel_s)  scratch_r    <= wdata_in;
      if (sel_ca) trim_r       <= wdata_in & MASK_BIT0;
      if (addr_in == OFS_WIN_LO_L) win_lo_r[7:0]  <= wdata_in;
      if (addr_in == OFS_WIN_LO_H) win_lo_r[15:8] <= wdata_in;
      if (addr_in == OFS_WIN_HI_L) win_hi_r[7:0]  <= wdata_in;
      if (addr_in == OFS_WIN_HI_H) win_hi_r[15:8] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      start_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      start_r <= go;
    end else if (state_nxt == ST_IDLE) begin
      start_r <= 1'b0;
    end
  end

  // result and sticky flags; set wins over read clear
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result_r    <= 16'h0000;
      irq_flags_r <= REG_RESET;
    end else begin
      if (state_r == ST_SAMP && sample_done_in && last) begin
        result_r <= acc_sum;
        irq_flags_r[POS_IRQ_RES] <= 1'b1;
        irq_flags_r[POS_IRQ_WIN] <= win_hit | irq_flags_r[POS_IRQ_WIN];
      end else if (rd_in && sel_if) begin
        irq_flags_r <= REG_RESET;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_in)
      OFS_CONTROL_A:  rd_mux = control_a_r;
      OFS_CONTROL_B:  rd_mux = control_b_r;
      OFS_CONTROL_C:  rd_mux = control_c_r;
      OFS_CONTROL_D:  rd_mux = {control_d_r[7:4], dly_r};
      OFS_CONTROL_E:  rd_mux = control_e_r;
      OFS_SAMPLE_LEN: rd_mux = sample_len_r;
      OFS_INPUT_SEL:  rd_mux = input_sel_r;
      OFS_COMMAND:    rd_mux = {7'h00, start_r};
      OFS_TRIGGER:    rd_mux = trigger_r;
      OFS_IRQ_EN:     rd_mux = irq_en_r;
      OFS_IRQ_FLAGS:  rd_mux = irq_flags_r;
      OFS_HALT:       rd_mux = halt_r;
      OFS_SCRATCH:    rd_mux = scratch_r;
      OFS_RESULT_LO:  rd_mux = result_r[7:0];
      OFS_RESULT_HI:  rd_mux = result_r[15:8];
      OFS_WIN_LO_L:   rd_mux = win_lo_r[7:0];
      OFS_WIN_LO_H:   rd_mux = win_lo_r[15:8];
      OFS_WIN_HI_L:   rd_mux = win_hi_r[7:0];
      OFS_WIN_HI_H:   rd_mux = win_hi_r[15:8];
      OFS_TRIM:       rd_mux = trim_r;
      default:        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_in ? rd_mux : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_out             = rdata_r;
  assign conv_on_out           = active;
  assign conv_tick_out         = conv_tick;
  assign sample_req_out        = state_r == ST_SAMP;
  assign sample_open_out       = state_r == ST_GAP;
  assign reference_choice_out  = control_c_r[5:4];
  assign sample_cap_reduce_out = control_c_r[POS_CAP_RED];
  assign input_select_out      = input_sel_r[4:0];
  assign sample_len_out        = sample_len_r[4:0];
  assign irq_out               = |(irq_flags_r & irq_en_r);

endmodule : adc_control

//--- common/adc_ctrl_pkg.sv
// package: register map, field layout and types of the converter control
// assumes: 8-bit register port, 40 MHz peripheral clock
package adc_ctrl_pkg;

  // register offsets
  localparam logic [4:0] OFS_CONTROL_A  = 5'h00;
  localparam logic [4:0] OFS_CONTROL_B  = 5'h01;
  localparam logic [4:0] OFS_CONTROL_C  = 5'h02;
  localparam logic [4:0] OFS_CONTROL_D  = 5'h03;
  localparam logic [4:0] OFS_CONTROL_E  = 5'h04;
  localparam logic [4:0] OFS_SAMPLE_LEN = 5'h05;
  localparam logic [4:0] OFS_INPUT_SEL  = 5'h06;
  localparam logic [4:0] OFS_COMMAND    = 5'h08;
  localparam logic [4:0] OFS_TRIGGER    = 5'h09;
  localparam logic [4:0] OFS_IRQ_EN     = 5'h0a;
  localparam logic [4:0] OFS_IRQ_FLAGS  = 5'h0b;
  localparam logic [4:0] OFS_HALT       = 5'h0c;
  localparam logic [4:0] OFS_SCRATCH    = 5'h0d;
  localparam logic [4:0] OFS_RESULT_LO  = 5'h10;
  localparam logic [4:0] OFS_RESULT_HI  = 5'h11;
  localparam logic [4:0] OFS_WIN_LO_L   = 5'h12;
  localparam logic [4:0] OFS_WIN_LO_H   = 5'h13;
  localparam logic [4:0] OFS_WIN_HI_L   = 5'h14;
  localparam logic [4:0] OFS_WIN_HI_H   = 5'h15;
  localparam logic [4:0] OFS_TRIM       = 5'h16;

  // reset value and writable masks
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] MASK_CTRL_A  = 8'h85;
  localparam logic [7:0] MASK_CTRL_B  = 8'h07;
  localparam logic [7:0] MASK_CTRL_C  = 8'h77;
  localparam logic [7:0] MASK_CTRL_E  = 8'h07;
  localparam logic [7:0] MASK_5BIT    = 8'h1f;
  localparam logic [7:0] MASK_BIT0    = 8'h01;
  localparam logic [7:0] MASK_IRQ     = 8'h03;

  // field positions
  localparam int POS_ENABLE   = 0;
  localparam int POS_RES_SEL  = 2;
  localparam int POS_STBY_RUN = 7;
  localparam int POS_CAP_RED  = 6;
  localparam int POS_REF_LO   = 4;
  localparam int POS_DITHER   = 4;
  localparam int POS_STARTUP  = 5;
  localparam int POS_IRQ_RES  = 0;
  localparam int POS_IRQ_WIN  = 1;

  // reserved codes and timing
  localparam logic [2:0] ACC_RESERVED  = 3'h7;
  localparam logic [2:0] DLY_MAX_CODE  = 3'h5;
  localparam logic [1:0] REF_INTERNAL  = 2'h0;
  localparam logic [1:0] REF_SUPPLY    = 2'h1;
  localparam logic [1:0] REF_EXTERNAL  = 2'h2;
  localparam logic [3:0] DITHER_WRAP   = 4'hf;
  localparam int         STARTUP_UNIT  = 16;
  localparam int         CONV_CLOCKS   = 13;

  // converter sample interface
  typedef struct packed {
    logic       req;
    logic       done;
    logic [9:0] data;
  } sample_if_t;

endpackage : adc_ctrl_pkg

//--- rtl/adc_clk_divider.sv
// clock prescaler: one-cycle enable every 2**(code+1) clocks
// assumes: single clock, synchronous reset
`timescale 1ns/1ps
module adc_clk_divider (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // control
  input  wire logic       run_in,
  input  wire logic [2:0] code_in,
  // enable
  output logic            tick_out
);
  logic [7:0] cnt_r;
  wire  [7:0] limit = 8'((9'h002 << code_in) - 9'h001);

  always_ff @(posedge clk_in) begin
    if (srst_in || !run_in || cnt_r >= limit) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tick_out = run_in && (cnt_r >= limit);
endmodule : adc_clk_divider

//--- test/adc_control_monitor.sv
// checker: port-level properties of the converter control block
// assumes: bound to adc_control, one clock, synchronous reset
`timescale 1ns/1ps
module adc_control_monitor
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic       clk_in,
  input wire logic       srst_in,
  // register port
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  // system and core
  input wire logic       standby_in,
  input wire logic       conv_on_out,
  input wire logic       sample_req_out,
  input wire logic       sample_open_out,
  input wire logic       sample_done_in,
  input wire logic       conv_tick_out,
  input wire logic [1:0] reference_choice_out,
  input wire logic       sample_cap_reduce_out,
  input wire logic [4:0] sample_len_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////////////////////////////////////////
  // shadow copies of written fields
  logic [7:0] a_r, c_r, d_r;
  logic [4:0] len_r;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      a_r   <= 8'h00;
      c_r   <= 8'h00;
      d_r   <= 8'h00;
      len_r <= 5'h00;
    end else if (wr_in) begin
      if (addr_in == OFS_CONTROL_A) a_r <= wdata_in & MASK_CTRL_A;
      if (addr_in == OFS_CONTROL_C) c_r <= wdata_in & MASK_CTRL_C;
      if (addr_in == OFS_CONTROL_D) d_r <= wdata_in;
      if (addr_in == OFS_SAMPLE_LEN) len_r <= wdata_in[4:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_enable_power: assert property (
    conv_on_out == (a_r[POS_ENABLE] && (!standby_in || a_r[POS_STBY_RUN])))
    else $error("converter power does not follow enable and standby");
  a_rdata_quiet: assert property (
    !$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctrl_d_read: assert property (
    rd_in && addr_in == OFS_CONTROL_D |=> rdata_out[7:4] == $past(d_r[7:4]))
    else $error("control_d upper fields read wrong");
  a_ref_fields: assert property (
    {sample_cap_reduce_out, reference_choice_out} == c_r[6:4])
    else $error("reference or capacitance output wrong");
  a_tick_single: assert property (
    conv_tick_out |=> !conv_tick_out)
    else $error("converter clock enable longer than one cycle");
  a_tick_div2: assert property (
    conv_tick_out && c_r[2:0] == 3'h0 && conv_on_out
    ##1 (c_r[2:0] == 3'h0 && conv_on_out) [*2] |-> conv_tick_out)
    else $error("divide by two period wrong");
  a_req_held: assert property (
    sample_req_out && !sample_done_in && conv_on_out |=> sample_req_out)
    else $error("sample request dropped before done");
  a_gap_closed: assert property (
    !(sample_open_out && sample_req_out))
    else $error("gap and sampling at the same time");
  a_busy_read: assert property (
    rd_in && addr_in == OFS_COMMAND && sample_req_out |=> rdata_out == 8'h01)
    else $error("start bit not read as busy");
  a_len_field: assert property (
    sample_len_out == len_r)
    else $error("sample length output wrong");

  a_gap_after_done: assert property (
    $rose(sample_open_out) |-> $past(sample_req_out) && $past(sample_done_in))
    else $error("gap opened without a finished sample");
  a_irq_read_clear: assert property (
    rd_in && addr_in == OFS_IRQ_FLAGS && !sample_done_in |=> !irq_out)
    else $error("interrupt still high after flag read");

  c_sample: cover property ($rose(sample_req_out));
  c_gap: cover property ($rose(sample_open_out));
  c_irq: cover property ($rose(irq_out));
  c_tick: cover property (conv_tick_out);
endmodule : adc_control_monitor

bind adc_control adc_control_monitor i_mon (
  .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .standby_in(standby_in),
  .conv_on_out(conv_on_out), .sample_req_out(sample_req_out),
  .sample_open_out(sample_open_out), .sample_done_in(sample_done_in),
  .conv_tick_out(conv_tick_out),
  .reference_choice_out(reference_choice_out),
  .sample_cap_reduce_out(sample_cap_reduce_out),
  .sample_len_out(sample_len_out), .irq_out(irq_out));

//--- test/adc_control_tb.sv
// testbench: register and conversion sequences for adc_control
// assumes: bench answers sample requests in place of the analog core
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR at %0t: got %0h exp %0h", $time, g, e); \
  end end
module adc_control_tb;
  import adc_ctrl_pkg::*;
  logic       clk_in = 1'b0, srst_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0, rd_in = 1'b0;
  logic       standby_in = 1'b0, trigger_in = 1'b0;
  logic       sample_done_in = 1'b0;
  logic [9:0] sample_data_in = 10'h000;
  logic [7:0] rdata_out;
  logic [1:0] reference_choice_out;
  logic [4:0] input_select_out, sample_len_out;
  logic       conv_on_out, sample_req_out, sample_open_out, conv_tick_out;
  logic       sample_cap_reduce_out, irq_out;
  logic [15:0] s;
  int error_cnt = 0, samples_checked = 0;
  int waited, first_wait, open_cnt, g, n;

  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (sample_open_out === 1'b1) open_cnt++;

  adc_control i_dut (
    .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .standby_in(standby_in),
    .trigger_in(trigger_in), .conv_on_out(conv_on_out),
    .sample_req_out(sample_req_out), .sample_open_out(sample_open_out),
    .sample_done_in(sample_done_in), .sample_data_in(sample_data_in),
    .conv_tick_out(conv_tick_out),
    .reference_choice_out(reference_choice_out),
    .sample_cap_reduce_out(sample_cap_reduce_out),
    .input_select_out(input_select_out), .sample_len_out(sample_len_out),
    .irq_out(irq_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask : rdc
  task automatic fill(input logic [4:0] a, input logic [7:0] e);
    wr(a, 8'hff);
    rdc(a, e);
    wr(a, 8'h00);
  endtask : fill
  task automatic wait_req(input logic lvl);
    waited = 0;
    while (sample_req_out !== lvl && waited < 3000) begin
      @(posedge clk_in);
      #1;
      waited++;
    end
    if (waited >= 3000) begin
      error_cnt++;
      $display("ERROR at %0t: sample request wait expired", $time);
    end
  endtask : wait_req
  task automatic tick_gap(output int p);
    p = 0;
    while (conv_tick_out !== 1'b1 && p < 600) begin
      @(posedge clk_in);
      #1;
      p++;
    end
    p = 0;
    do begin
      @(posedge clk_in);
      #1;
      p++;
    end while (conv_tick_out !== 1'b1 && p < 600);
  endtask : tick_gap
  task automatic conv(input int k, input logic rs, input logic trig,
                      output logic [15:0] sum);
    logic [9:0] d;
    logic [7:0] v;
    sum = 16'h0000;
    if (trig) begin
      @(posedge clk_in);
      trigger_in <= 1'b1;
      @(posedge clk_in);
      trigger_in <= 1'b0;
    end else
      wr(OFS_COMMAND, 8'h01);
    rdc(OFS_COMMAND, 8'h01);
    for (int i = 0; i < k; i++) begin
      d = 10'h2c3 + 10'(i * 37);
      wait_req(1'b1);
      if (i == 0) first_wait = waited;
      @(posedge clk_in);
      sample_done_in <= 1'b1;
      sample_data_in <= d;
      @(posedge clk_in);
      sample_done_in <= 1'b0;
      sample_data_in <= ~d;
      #1;
      if (i == k - 1) wait_req(1'b0);
      sum = sum + (rs ? 16'(d[9:2]) : 16'(d));
    end
    v = 8'h01;
    for (int j = 0; j < 20 && v[0] !== 1'b0; j++) rd(OFS_COMMAND, v);
    `CHK(v, 8'h00)
  endtask : conv
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    $display("ERROR at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    for (int a = 0; a < 32; a++) rdc(5'(a), 8'h00);
    fill(OFS_CONTROL_A, MASK_CTRL_A);
    fill(OFS_CONTROL_B, MASK_CTRL_B);
    fill(OFS_CONTROL_C, MASK_CTRL_C);
    fill(OFS_CONTROL_D, 8'hff);
    fill(OFS_SAMPLE_LEN, MASK_5BIT);
    fill(5'h07, 8'h00);
    wr(OFS_INPUT_SEL, 8'hff);
    `CHK(input_select_out, 5'h1f)
    wr(OFS_INPUT_SEL, 8'h00);
    `CHK(input_select_out, 5'h00)
    wr(OFS_CONTROL_A, 8'h01);
    `CHK(conv_on_out, 1'b1)
    @(posedge clk_in);
    standby_in <= 1'b1;
    @(posedge clk_in);
    #1 `CHK(conv_on_out, 1'b0)
    wr(OFS_CONTROL_A, 8'h81);
    `CHK(conv_on_out, 1'b1)
    @(posedge clk_in);
    standby_in <= 1'b0;
    wr(OFS_CONTROL_A, 8'h00);
    `CHK(conv_on_out, 1'b0)
    wr(OFS_COMMAND, 8'h01);
    repeat (10) @(posedge clk_in);
    #1 `CHK(sample_req_out, 1'b0)
    rdc(OFS_COMMAND, 8'h00);
    wr(OFS_CONTROL_A, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_CONTROL_C, 8'(c));
      tick_gap(g);
      tick_gap(g);
      `CHK(g, 2 << c)
    end
    // bench steps all eight codes, internal reference (r = 0) included
    for (int r = 0; r < 8; r++) begin
      wr(OFS_CONTROL_C, 8'(r << 4));
      `CHK({sample_cap_reduce_out, reference_choice_out}, 3'(r))
      `CHK(sample_cap_reduce_out, 1'(r >> 2))
    end
    wr(OFS_CONTROL_C, 8'h00);
    wr(OFS_TRIGGER, 8'h01);
    wr(OFS_IRQ_EN, 8'h01);
    for (int t = 0; t < 6; t++) begin
      wr(OFS_CONTROL_A, t % 2 ? 8'h05 : 8'h01);
      wr(OFS_CONTROL_B, 8'(t + 2 * (t / 4)));
      n = (t == 5) ? 1 : 1 << (t + 2 * (t / 4));
      conv(n, 1'(t % 2), t == 2, s);
      `CHK(irq_out, 1'b1)
      rdc(OFS_RESULT_LO, s[7:0]);
      rdc(OFS_RESULT_HI, s[15:8]);
      rdc(OFS_IRQ_FLAGS, 8'h01);
      `CHK(irq_out, 1'b0)
    end
    wr(OFS_IRQ_EN, 8'h00);
    wr(OFS_CONTROL_A, 8'h01);
    wr(OFS_CONTROL_B, 8'h01);
    wr(OFS_CONTROL_D, 8'h03);
    open_cnt = 0;
    conv(2, 1'b0, 1'b0, s);
    `CHK(open_cnt >= 5 && open_cnt <= 7, 1'b1)
    `CHK(irq_out, 1'b0)
    wr(OFS_CONTROL_D, 8'h13);
    conv(2, 1'b0, 1'b0, s);
    rdc(OFS_CONTROL_D, 8'h15);
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_CONTROL_D, 8'h1f);
    conv(1, 1'b0, 1'b0, s);
    rdc(OFS_CONTROL_D, 8'h10);
    wr(OFS_CONTROL_A, 8'h00);
    wr(OFS_CONTROL_D, 8'h20);
    wr(OFS_CONTROL_A, 8'h01);
    conv(1, 1'b0, 1'b0, s);
    `CHK(first_wait >= 20 && first_wait <= 40, 1'b1)
    rdc(OFS_IRQ_FLAGS, 8'h01);
    wrap_up();
  end
endmodule : adc_control_tb
